/* File: logic/pfc_defs.svh */
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

// ---------------------------------------------------------------
// Address map (offset within the 11-bit I/O window)
// ---------------------------------------------------------------
`define PFC_ADDR_W         11
`define PFC_A_DATA         11'h000
`define PFC_A_STATUS       11'h001
`define PFC_A_CONTROL      11'h002
`define PFC_A_FIFO         11'h400
`define PFC_A_CAPB         11'h401
`define PFC_A_EXTCTL       11'h402

// ---------------------------------------------------------------
// Field positions and constants
// ---------------------------------------------------------------
`define PFC_ECR_FAULT_DIS  4
`define PFC_ECR_DMA_EN     3
`define PFC_ECR_SVC        2
`define PFC_DCR_DIR        5
`define PFC_CAPA_VALUE     8'h10
`define PFC_ECR_RST_MODE   3'h0
`define PFC_ECR_RST_BITS   3'h5
`define PFC_FIFO_DEPTH     16
`define PFC_CNT_W          5
`define PFC_WRITE_THRESH   5'h08
`define PFC_READ_THRESH    5'h08
`define PFC_STROBE_NS      500
`define PFC_CLK_MHZ        125
`define PFC_STROBE_CYC     ((`PFC_STROBE_NS * `PFC_CLK_MHZ + 999) / 1000)
`endif

/* File: logic/pfc_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pfc_defs.svh"
module pfc_fifo (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   flush,
    input  wire logic                   push,
    input  wire pfc_pkg::pfc_entry_t    push_data,
    input  wire logic                   pop,
    output pfc_pkg::pfc_entry_t         head,
    output logic [`PFC_CNT_W-1:0]       count,
    output logic                        full,
    output logic                        empty
);
    import pfc_pkg::*;

    pfc_entry_t                 mem [0:`PFC_FIFO_DEPTH-1];
    logic [`PFC_CNT_W-2:0]      wr_ptr_r;
    logic [`PFC_CNT_W-2:0]      rd_ptr_r;
    logic [`PFC_CNT_W-1:0]      count_r;
    logic                       do_push;
    logic                       do_pop;

    // Overflow and underflow are dropped here, not at each caller
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign full    = (count_r == `PFC_CNT_W'(`PFC_FIFO_DEPTH));
    assign empty   = (count_r == '0);
    assign count   = count_r;
    assign head    = mem[rd_ptr_r];

    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + {4'h0, do_push} - {4'h0, do_pop};
        end
    end
endmodule // pfc_fifo
`default_nettype wire

/* File: logic/pfc_pkg.sv */
package pfc_pkg;
    typedef enum logic [2:0] {
        MODE_STD    = 3'b000,
        MODE_BIDIR  = 3'b001,
        MODE_PFIFO  = 3'b010,
        MODE_ECP    = 3'b011,
        MODE_RSV4   = 3'b100,
        MODE_RSV5   = 3'b101,
        MODE_TEST   = 3'b110,
        MODE_CONFIG = 3'b111
    } pfc_mode_t;

    typedef enum logic [2:0] {
        ENG_IDLE    = 3'b000,
        ENG_SETUP   = 3'b001,
        ENG_STROBE  = 3'b010,
        ENG_HOLD    = 3'b011,
        ENG_REV_REQ = 3'b100,
        ENG_REV_REL = 3'b101
    } pfc_eng_t;

    typedef struct packed {
        logic       is_addr;
        logic [7:0] data;
    } pfc_entry_t;

    typedef struct packed {
        logic [7:0] port_data_bus;
        logic       busy;
        logic       ack_n;
        logic       perror;
        logic       select;
        logic       peripheral_fault_n;
    } pfc_pins_t;
endpackage

/* File: logic/pfc_port.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pfc_defs.svh"
module pfc_port (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic [`PFC_ADDR_W-1:0] io_addr,
    input  wire logic                   io_rd,
    input  wire logic                   io_wr,
    input  wire logic [7:0]             io_wdata,
    output logic [7:0]                  io_rdata,
    output logic                        dma_req,
    input  wire logic                   dma_ack,
    input  wire logic                   dma_tc,
    output logic                        irq,
    input  wire pfc_pkg::pfc_pins_t     pins_in,
    output logic [7:0]                  port_data_bus_out,
    output logic                        port_data_bus_oe,
    output logic                        host_strobe_out_n,
    output logic                        host_ack_out_n,
    output logic                        init_out_n,
    output logic                        select_in_out_n
);
    import pfc_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    pfc_pins_t              sync1_r;
    pfc_pins_t              sync2_r;
    logic                   fault_n_d_r;
    logic [7:0]             data_latch_r;
    logic [5:0]             dcr_r;
    pfc_mode_t              mode_r;
    pfc_mode_t              mode_d_r;
    logic                   fault_dis_r;
    logic                   dma_en_r;
    logic                   svc_r;
    logic [7:0]             rdata_r;
    logic [7:0]             last_rd_r;
    logic                   irq_r;
    pfc_eng_t               st_r;
    logic [7:0]             pd_drv_r;
    logic                   cmd_r;
    logic                   eng_strobe_n_r;
    logic                   eng_ack_n_r;
    logic [7:0]             cnt_r;
    logic                   dir;
    logic                   fifo_mode;
    logic                   fwd_ecp;
    logic                   fwd_run;
    logic                   rev_run;
    logic                   acc_fifo;
    logic                   wr_fifo;
    logic                   wr_addr_q;
    logic                   rd_fifo;
    logic                   wr_ecr;
    logic                   eng_pop;
    logic                   eng_push;
    logic                   q_push;
    logic                   q_pop;
    pfc_entry_t             q_in;
    pfc_entry_t             q_head;
    logic [`PFC_CNT_W-1:0]  q_count;
    logic                   q_full;
    logic                   q_empty;
    logic [`PFC_CNT_W-1:0]  q_free;
    logic                   svc_event;
    logic                   fault_event;
    logic [7:0]             ecr_rd;
    logic [7:0]             capb_rd;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_r     <= '1;
            sync2_r     <= '1;
            fault_n_d_r <= 1'b1;
        end else begin
            sync1_r     <= pins_in;
            sync2_r     <= sync1_r;
            fault_n_d_r <= sync2_r.peripheral_fault_n;
        end
    end

    // ---------------------------------------------------------------
    // Mode and direction decode
    // ---------------------------------------------------------------
    // Standard and parallel FIFO modes are forward only
    assign dir       = (mode_r == MODE_STD || mode_r == MODE_PFIFO) ? 1'b0
                     : dcr_r[`PFC_DCR_DIR];
    assign fifo_mode = (mode_r == MODE_PFIFO) || (mode_r == MODE_ECP)
                     || (mode_r == MODE_TEST);
    assign fwd_ecp   = (mode_r == MODE_ECP) && !dir;
    assign fwd_run   = (mode_r == MODE_PFIFO) || fwd_ecp;
    assign rev_run   = (mode_r == MODE_ECP) && dir;
    assign acc_fifo  = dma_ack || (io_addr == `PFC_A_FIFO);

    // ---------------------------------------------------------------
    // Host access decode
    // ---------------------------------------------------------------
    assign wr_fifo   = io_wr && acc_fifo && (fwd_run || mode_r == MODE_TEST);
    assign wr_addr_q = io_wr && !dma_ack && (io_addr == `PFC_A_DATA) && fwd_ecp;
    assign rd_fifo   = io_rd && acc_fifo && (rev_run || mode_r == MODE_TEST);
    assign wr_ecr    = io_wr && !dma_ack && (io_addr == `PFC_A_EXTCTL);

    assign eng_pop   = (st_r == ENG_IDLE) && fwd_run && !q_empty && !sync2_r.busy;
    assign eng_push  = (st_r == ENG_REV_REQ) && rev_run && !sync2_r.ack_n && !q_full;

    // Address bytes carry their tag through the shared queue
    always_comb begin
        q_in = '0;
        if (eng_push) begin
            q_in.data    = sync2_r.port_data_bus;
            q_in.is_addr = !sync2_r.busy;
        end else begin
            q_in.data    = io_wdata;
            q_in.is_addr = wr_addr_q;
        end
    end
    assign q_push = eng_push || wr_fifo || wr_addr_q;
    assign q_pop  = eng_pop || rd_fifo;

    pfc_fifo u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .flush     (mode_r == MODE_STD),
        .push      (q_push),
        .push_data (q_in),
        .pop       (q_pop),
        .head      (q_head),
        .count     (q_count),
        .full      (q_full),
        .empty     (q_empty)
    );

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_latch_r <= 8'h00;
            dcr_r        <= 6'h00;
        end else if (io_wr && !dma_ack) begin
            if (io_addr == `PFC_A_DATA && !fwd_ecp) begin
                data_latch_r <= io_wdata;
            end
            if (io_addr == `PFC_A_CONTROL) begin
                dcr_r <= io_wdata[5:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_r      <= pfc_mode_t'(`PFC_ECR_RST_MODE);
            fault_dis_r <= 1'(`PFC_ECR_RST_BITS >> 2);
            dma_en_r    <= 1'b0;
        end else if (wr_ecr) begin
            mode_r      <= pfc_mode_t'(io_wdata[7:5]);
            fault_dis_r <= io_wdata[`PFC_ECR_FAULT_DIS];
            dma_en_r    <= io_wdata[`PFC_ECR_DMA_EN];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_d_r <= pfc_mode_t'(`PFC_ECR_RST_MODE);
        end else begin
            mode_d_r <= mode_r;
        end
    end

    // ---------------------------------------------------------------
    // Service and fault interrupts
    // ---------------------------------------------------------------
    assign q_free = `PFC_CNT_W'(`PFC_FIFO_DEPTH) - q_count;
    always_comb begin
        svc_event = 1'b0;
        if (!svc_r && fifo_mode) begin
            if (dma_en_r) begin
                svc_event = dma_tc && dma_ack;
            end else if (!dir) begin
                svc_event = (q_free >= `PFC_WRITE_THRESH);
            end else begin
                svc_event = (q_count >= `PFC_READ_THRESH);
            end
        end
    end

    // Edge, or disable bit cleared while the fault is already low
    assign fault_event = (mode_r == MODE_ECP) && (
                         (!fault_dis_r && fault_n_d_r && !sync2_r.peripheral_fault_n)
                         || (wr_ecr && fault_dis_r && !io_wdata[`PFC_ECR_FAULT_DIS]
                             && !sync2_r.peripheral_fault_n));

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            svc_r <= 1'(`PFC_ECR_RST_BITS & 3'h1);
        end else if (svc_event) begin
            svc_r <= 1'b1;
        end else if (wr_ecr) begin
            svc_r <= io_wdata[`PFC_ECR_SVC];
        end
    end

    // ISA pulse interrupt, one cycle wide
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= svc_event || fault_event;
        end
    end
    assign irq = irq_r;

    assign dma_req = dma_en_r && !svc_r && fifo_mode
                   && (dir ? !q_empty : !q_full);

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    assign ecr_rd  = {mode_r, fault_dis_r, dma_en_r, svc_r, q_full, q_empty};
    assign capb_rd = {1'b0, irq_r, 3'b000, 3'b000};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r   <= 8'h00;
            last_rd_r <= 8'h00;
        end else if (io_rd) begin
            if (dma_ack || io_addr == `PFC_A_FIFO) begin
                if (mode_r == MODE_CONFIG && !dma_ack) begin
                    rdata_r <= `PFC_CAPA_VALUE;
                end else if (rd_fifo && !q_empty) begin
                    rdata_r   <= q_head.data;
                    last_rd_r <= q_head.data;
                end else begin
                    rdata_r <= last_rd_r;
                end
            end else if (io_addr == `PFC_A_DATA) begin
                rdata_r <= (mode_r == MODE_BIDIR && dir) ? sync2_r.port_data_bus
                         : data_latch_r;
            end else if (io_addr == `PFC_A_STATUS) begin
                rdata_r <= {!sync2_r.busy, sync2_r.ack_n, sync2_r.perror,
                            sync2_r.select, sync2_r.peripheral_fault_n, 3'b111};
            end else if (io_addr == `PFC_A_CONTROL) begin
                rdata_r <= {2'b11, dir, dcr_r[4:0]};
            end else if (io_addr == `PFC_A_CAPB && mode_r == MODE_CONFIG) begin
                rdata_r <= capb_rd;
            end else if (io_addr == `PFC_A_EXTCTL) begin
                rdata_r <= ecr_rd;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end
    assign io_rdata = rdata_r;

    // ---------------------------------------------------------------
    // Peripheral handshake engine
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r           <= ENG_IDLE;
            pd_drv_r       <= 8'h00;
            cmd_r          <= 1'b0;
            eng_strobe_n_r <= 1'b1;
            eng_ack_n_r    <= 1'b1;
            cnt_r          <= 8'h00;
        end else if (mode_r != mode_d_r || !(fwd_run || rev_run)) begin
            st_r           <= ENG_IDLE;
            eng_strobe_n_r <= 1'b1;
            eng_ack_n_r    <= 1'b1;
        end else begin
            case (st_r)
                ENG_IDLE: begin
                    if (rev_run) begin
                        eng_ack_n_r <= 1'b0;
                        st_r        <= ENG_REV_REQ;
                    end else if (eng_pop) begin
                        pd_drv_r <= q_head.data;
                        cmd_r    <= q_head.is_addr;
                        st_r     <= ENG_SETUP;
                    end
                end
                ENG_SETUP: begin
                    eng_strobe_n_r <= 1'b0;
                    cnt_r          <= 8'(`PFC_STROBE_CYC - 1);
                    st_r           <= ENG_STROBE;
                end
                ENG_STROBE: begin
                    if (fwd_ecp ? sync2_r.busy : (cnt_r == 8'h00)) begin
                        eng_strobe_n_r <= 1'b1;
                        st_r           <= ENG_HOLD;
                    end else if (cnt_r != 8'h00) begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                ENG_HOLD: begin
                    if (!fwd_ecp || !sync2_r.busy) begin
                        st_r <= ENG_IDLE;
                    end
                end
                ENG_REV_REQ: begin
                    if (eng_push) begin
                        eng_ack_n_r <= 1'b1;
                        st_r        <= ENG_REV_REL;
                    end
                end
                ENG_REV_REL: begin
                    if (sync2_r.ack_n) begin
                        eng_ack_n_r <= 1'b0;
                        st_r        <= ENG_REV_REQ;
                    end
                end
                default: begin
                    st_r <= ENG_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Pin drivers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_data_bus_out <= 8'h00;
            port_data_bus_oe  <= 1'b1;
            host_strobe_out_n <= 1'b1;
            host_ack_out_n    <= 1'b1;
            init_out_n        <= 1'b0;
            select_in_out_n   <= 1'b1;
        end else begin
            port_data_bus_oe <= !dir;
            if (fwd_run) begin
                port_data_bus_out <= pd_drv_r;
            end else if (mode_r == MODE_TEST) begin
                port_data_bus_out <= q_head.data;
            end else begin
                port_data_bus_out <= data_latch_r;
            end
            host_strobe_out_n <= fwd_run ? eng_strobe_n_r : !dcr_r[0];
            if (fwd_ecp) begin
                host_ack_out_n <= cmd_r;
            end else if (rev_run) begin
                host_ack_out_n <= eng_ack_n_r;
            end else begin
                host_ack_out_n <= !dcr_r[1];
            end
            init_out_n      <= dcr_r[2];
            select_in_out_n <= !dcr_r[3];
        end
    end
endmodule // pfc_port
`default_nettype wire

/* File: verif/pfc_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module pfc_asserts (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [10:0] io_addr,
    input wire logic        io_rd,
    input wire logic        io_wr,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        dma_req,
    input wire logic        dma_ack,
    input wire logic        dma_tc,
    input wire logic        irq,
    input wire logic        port_data_bus_oe,
    input wire logic        host_ack_out_n
);
    logic [2:0] mode_r;
    // Shadow of the mode field, rebuilt from register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_r <= 3'h0;
        end else if (io_wr && !dma_ack && io_addr == 11'h402) begin
            mode_r <= io_wdata[7:5];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence cfg_rd(a);
        io_rd && !dma_ack && io_addr == a && mode_r == 3'h7;
    endsequence
    sequence ecr_rd;
        io_rd && !dma_ack && io_addr == 11'h402;
    endsequence
    sequence ecr_wr;
        io_wr && !dma_ack && io_addr == 11'h402;
    endsequence
    sequence std2;
        mode_r == 3'h0 && $past(mode_r) == 3'h0;
    endsequence
    sequence tc_hit;
        dma_ack && dma_tc && io_wr && dma_req;
    endsequence
    capa_value_a: assert property (cfg_rd(11'h400) |=> io_rdata == 8'h10)
        else $error("capability A wrong");
    capb_zero_a: assert property (cfg_rd(11'h401) |=> {io_rdata[7], io_rdata[5:0]} == 7'h00)
        else $error("capability B wrong");
    mode_back_a: assert property (ecr_wr ##1 ecr_rd |=> io_rdata[7:5] == $past(io_wdata[7:5], 2))
        else $error("mode field readback wrong");
    std_fwd_a: assert property (std2 |-> port_data_bus_oe)
        else $error("bus not driven in mode 000");
    empty_std_a: assert property (std2 ##0 ecr_rd |=> io_rdata[1:0] == 2'b01)
        else $error("fifo not flushed in mode 000");
    tc_irq_a: assert property (tc_hit |=> irq)
        else $error("no irq on terminal count");
    tc_stop_a: assert property (tc_hit |=> !dma_req [*2])
        else $error("dma request after terminal count");
    ack_drop_a: assert property ($past(mode_r) == 3'h3 && mode_r != 3'h3 |-> ##[0:2] host_ack_out_n)
        else $error("host ack held after mode change");
endmodule // pfc_asserts
bind pfc_port pfc_asserts pfc_asserts_i (
    .clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .dma_req(dma_req), .dma_ack(dma_ack),
    .dma_tc(dma_tc), .irq(irq), .port_data_bus_oe(port_data_bus_oe),
    .host_ack_out_n(host_ack_out_n)
);
`default_nettype wire

/* File: verif/pfc_periph.sv */
`timescale 1ns/100ps
`default_nettype none
module pfc_periph (
    input  wire logic          clk_sys,
    input  wire logic          rev_en,
    input  wire logic          slow,
    input  wire logic [7:0]    bus_out,
    input  wire logic          bus_oe,
    input  wire logic          strobe_n,
    input  wire logic          hack_n,
    output pfc_pkg::pfc_pins_t pins,
    output logic               got,
    output logic [7:0]         got_byte
);
    import pfc_pkg::*;
    logic [7:0] drv_r = 8'h5a;
    logic [7:0] seq_r = 8'ha0;
    logic [2:0] lag_r = 3'h0;
    logic       busy_r = 1'b0;
    logic       ack_r = 1'b1;
    logic       want;
    // Released bus shows the inverted last byte so stale data never matches
    assign pins = {bus_oe ? bus_out : drv_r, busy_r | rev_en, ack_r, 1'b0, 1'b1, 1'b1};
    assign want = rev_en ? (hack_n != ack_r) : (strobe_n == busy_r);
    initial got = 1'b0;
    always @(posedge clk_sys) begin
        got <= 1'b0;
        if (!want) begin
            lag_r <= 3'h0;
        end else if (lag_r != (slow ? 3'h5 : 3'h1)) begin
            lag_r <= lag_r + 3'h1;
        end else if (rev_en) begin
            lag_r <= 3'h0;
            ack_r <= ~ack_r;
            drv_r <= ack_r ? seq_r : ~drv_r;
            seq_r <= seq_r + {7'h00, ~ack_r};
        end else begin
            lag_r <= 3'h0;
            busy_r <= ~busy_r;
            got <= ~busy_r;
            got_byte <= pins.port_data_bus;
        end
    end
endmodule // pfc_periph
`default_nettype wire

/* File: verif/pfc_port_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pfc_defs.svh"
module pfc_port_tb_top;
    import pfc_pkg::*;
    localparam logic [10:0] ec_a = `PFC_A_EXTCTL;
    localparam logic [10:0] fi_a = `PFC_A_FIFO;
    logic        clk_sys = 1'b0, rst = 1'b1, io_rd = 1'b0, io_wr = 1'b0;
    logic        dma_ack = 1'b0, dma_tc = 1'b0, rev_en = 1'b0, slow = 1'b0, rd_seen = 1'b0;
    logic [10:0] io_addr = 11'h000;
    logic [7:0]  io_wdata = 8'h00, io_rdata, pd_out, got_byte, pb_q[$], tq[$];
    logic        dma_req, irq, pd_oe, stb_n, hack_n, got;
    logic [31:0] lfsr = 32'hafbaa59d;
    logic [15:0] rd_q[$];
    pfc_pins_t   pins;
    int          n_fail = 0, check_count = 0, cyc = 0;
    always #4 clk_sys = ~clk_sys;
    pfc_port pfc_port_i (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_rd(io_rd),
        .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .dma_req(dma_req),
        .dma_ack(dma_ack), .dma_tc(dma_tc), .irq(irq), .pins_in(pins), .port_data_bus_out(pd_out),
        .port_data_bus_oe(pd_oe), .host_strobe_out_n(stb_n), .host_ack_out_n(hack_n),
        .init_out_n(), .select_in_out_n());
    pfc_periph pfc_periph_i (.clk_sys(clk_sys), .rev_en(rev_en), .slow(slow), .bus_out(pd_out),
        .bus_oe(pd_oe), .strobe_n(stb_n), .hack_n(hack_n), .pins(pins), .got(got),
        .got_byte(got_byte));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic bus(input logic r, input logic w, input logic [10:0] a, input logic [7:0] d);
        io_rd <= r;
        io_wr <= w;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        bus(1'b0, 1'b1, a, d);
    endtask
    task automatic rd(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e);
        rd_q.push_back({m, e});
        bus(1'b1, 1'b0, a, 8'h00);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Missing notes force a mismatch, so unexpected results never pass silently
    always @(posedge clk_sys) begin
        if (rd_seen) begin
            logic [15:0] x;
            x = rd_q.size() > 0 ? rd_q.pop_front() : 16'h00ff;
            chk("io_rdata", x[7:0], io_rdata & x[15:8]);
        end
        rd_seen = io_rd;
        if (got) chk("periph_byte", pb_q.size() > 0 ? pb_q.pop_front() : ~got_byte, got_byte);
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ec_a, 8'hff, 8'h15);
        for (int m = 0; m < 8; m++) begin
            if (m == 4 || m == 5) continue;
            wr(ec_a, 8'h34);
            wr(ec_a, {m[2:0], 5'h14});
            rd(ec_a, 8'he0, {m[2:0], 5'h00});
        end
        rd(fi_a, 8'hff, 8'h10);
        rd(`PFC_A_CAPB, 8'hbf, 8'h00);
        wr(ec_a, 8'h34);
        wr(ec_a, 8'hd4);
        for (int i = 0; i < 17; i++) begin
            lfsr = nxt(lfsr);
            tq.push_back(lfsr[7:0]);
            wr(fi_a, lfsr[7:0]);
        end
        rd(ec_a, 8'h03, 8'h02);
        for (int i = 0; i < 17; i++) rd(fi_a, 8'hff, tq[i < 16 ? i : 15]);
        rd(ec_a, 8'h03, 8'h01);
        wr(ec_a, 8'h34);
        wr(ec_a, 8'h50);
        slow <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            lfsr = nxt(lfsr);
            pb_q.push_back(lfsr[7:0]);
            if (i == 4) begin
                // Last byte is a DMA write with terminal count, once DMA is enabled and requested
                wr(ec_a, 8'h48);
                wait (dma_req === 1'b1);
                @(posedge clk_sys);
                dma_ack <= 1'b1;
                dma_tc <= 1'b1;
            end
            wr(fi_a, lfsr[7:0]);
        end
        dma_ack <= 1'b0;
        dma_tc <= 1'b0;
        bus(1'b0, 1'b0, ec_a, 8'h00);
        wait (pb_q.size() == 0);
        @(posedge clk_sys);
        rd(ec_a, 8'h0d, 8'h0d);
        wr(ec_a, 8'h34);
        wr(`PFC_A_CONTROL, 8'h20);
        rev_en <= 1'b1;
        slow <= 1'b0;
        wr(ec_a, 8'h70);
        bus(1'b0, 1'b0, ec_a, 8'h00);
        wait (irq === 1'b1);
        @(posedge clk_sys);
        rd(ec_a, 8'h04, 8'h04);
        for (int i = 0; i < 8; i++) rd(fi_a, 8'hff, 8'ha0 + i[7:0]);
        wr(ec_a, 8'h34);
        wr(ec_a, 8'h14);
        bus(1'b0, 1'b0, ec_a, 8'h00);
        rd(ec_a, 8'h03, 8'h01);
        bus(1'b0, 1'b0, ec_a, 8'h00);
        repeat (4) @(posedge clk_sys);
        report_and_stop();
    end
endmodule // pfc_port_tb_top
`default_nettype wire
